// ==== hdl/bus_timer.sv ====
// Bus timer: minimum-time measurement and hang time-out.
// Assumes one tick per machine cycle and reload on every bus transition.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_cfg_map.svh"
module bus_timer #(
	parameter int WIDTH = `TIMER_WIDTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic tick,
	input wire logic clear,
	input wire logic reload,
	input wire logic [2:0] reload_value,
	input wire logic run_high,
	input wire logic frame,
	// Results
	output logic min_met,
	output logic timeout
);
	logic [WIDTH-1:0] count_reg;
	logic min_met_reg;
	logic timeout_reg;
	logic full_run;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	assign full_run = run_high && frame;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (reset || clear) begin
			count_reg <= '0;
		end else if (reload) begin
			count_reg <= WIDTH'(reload_value);
		end else if (tick) begin
			if (full_run) begin
				count_reg <= count_reg + WIDTH'(1);
			end else begin
				count_reg <= {{(WIDTH-3){1'b0}}, count_reg[2:0] + 3'h1};
			end
		end
	end

	// Carry out of the low three bits is the count of eight
	always_ff @(posedge clk) begin
		if (reset || clear || reload) begin
			min_met_reg <= 1'b0;
		end else if (tick && count_reg[2:0] == 3'h7) begin
			min_met_reg <= 1'b1;
		end
	end

	// Full wrap from the reload value gives 1016 plus the min count
	always_ff @(posedge clk) begin
		if (reset) begin
			timeout_reg <= 1'b0;
		end else begin
			timeout_reg <= tick && full_run && !reload && !clear && (&count_reg);
		end
	end

	assign min_met = min_met_reg;
	assign timeout = timeout_reg;

	////////////////////////////////////////////////////////////////////////////
	a_clear_zero: assert property (clear |=> count_reg == '0) else $error("timer not cleared");
	a_reload_load: assert property (reload && !clear |=> count_reg == WIDTH'($past(reload_value)))
		else $error("timer reload wrong");
	a_low_only: assert property (!run_high && !$past(run_high) |-> count_reg[WIDTH-1:3] == '0)
		else $error("high timer bits ran");
	a_timeout_wrap: assert property (timeout |-> count_reg == '0 && $past(full_run))
		else $error("time-out without full count");
endmodule // bus_timer
`default_nettype wire

// ==== hdl/i2c_cfg_map.svh ====
// Register offsets, field positions, reset values and timing counts of the serial bus configuration block.
// Assumes a byte-wide register port and a CPU clock with six clocks to one machine cycle.
//
// Overview of operation
// - Slave enable turns slave behaviour on
// - Both enables zero disables the whole interface once the master is idle
// - Reset and time-out clear slave enable
// - Master request waits for stop, then starts
// - Run bit counts; zero clears and stops the high bits
// - Transmit bit reaches SDA only while SCL low
// - Every SCL rising edge while enabled sets data ready
// - SCL low stretched while data ready pending
// - Master keeps minimum SCL high and low
// - Timer reloads eight minus count per transition
// - Time-out period follows min-time select
// - Time-out after 1023, 1022, 1021, 1020 cycles
// - Run bit zero: low three bits only
// - Run bit one: counts in frames, edges reload
`ifndef I2C_CFG_MAP_SVH
`define I2C_CFG_MAP_SVH

`define CFG_ADDR 8'hc8
`define CTRL_ADDR 8'hd8
`define DATA_ADDR 8'hd9
`define CFG_RESET 8'h00

`define CFG_SLAVE_EN_BIT 7
`define CFG_MASTER_REQ_BIT 6
`define CFG_TIMER_CLEAR_BIT 5
`define CFG_TIMER_RUN_BIT 4
`define CFG_SEL_HI_BIT 1
`define CFG_SEL_LO_BIT 0

`define CTRL_CLEAR_READY_BIT 5
`define CTRL_CLEAR_XMIT_BIT 1
`define CTRL_SEND_STOP_BIT 0
`define DATA_BIT 7

`define MACHINE_CLOCKS 3'h6
`define MIN_MET_COUNT 4'h8
`define MIN_COUNT_SEL2 3'h7
`define MIN_COUNT_SEL1 3'h6
`define MIN_COUNT_SEL0 3'h5
`define MIN_COUNT_SEL3 3'h4
`define TIMER_WIDTH 10

`endif

// ==== hdl/i2c_cfg_pkg.sv ====
// Types shared by the serial bus configuration block.
// Assumes nothing of its surroundings.
package i2c_cfg_pkg;
	typedef enum logic [2:0] {m_idle, m_start, m_low, m_high, m_stop} master_state_t;
	typedef logic [7:0] reg_byte_t;
endpackage

// ==== hdl/i2c_config_and_bus_timer.sv ====
// Serial bus configuration register, bus timer and bit-level bus driving.
// Assumes a byte-wide register port with read data one cycle after the strobe,
// and open-drain SCL and SDA resolved outside.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_cfg_map.svh"
module i2c_config_and_bus_timer
	import i2c_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Clock line of the bus
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Data line of the bus
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Status to the CPU core
	output logic attention
);
	localparam reg_byte_t CFG_RESET_VALUE = `CFG_RESET;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [7:0] a, input logic [7:0] offset);
		hit = (a == offset);
	endfunction

	function automatic logic [2:0] min_time_count(input logic [1:0] sel);
		case (sel)
			2'b10: min_time_count = `MIN_COUNT_SEL2;
			2'b01: min_time_count = `MIN_COUNT_SEL1;
			2'b00: min_time_count = `MIN_COUNT_SEL0;
			default: min_time_count = `MIN_COUNT_SEL3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic slave_en_reg, master_req_reg, timer_run_reg, overflow_reg, busy_reg;
	logic [1:0] min_sel_reg;
	logic bit_data_ready_reg, bit_data_ready_next, attention_reg, rx_bit_reg, tx_bit_reg, tx_active_reg, tx_applied_reg;
	logic stop_pending_reg, scl_d_reg, sda_d_reg, scl_oe_reg, sda_oe_reg, scl_out_reg, sda_out_reg;
	logic [7:0] rdata_reg;
	logic [2:0] mc_count_reg;
	master_state_t state_reg, state_next;

	logic [1:0] pins_s;
	logic [2:0] reload_value;
	logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen, enabled, master_active, mc_tick;
	logic timer_clear, timer_reload, min_met, timeout, cfg_wr, ctrl_wr, data_wr, data_rd;
	logic bit_data_ready_set, bit_data_ready_clr, stop_done;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	assign cfg_wr = wr && hit(addr, `CFG_ADDR);
	assign ctrl_wr = wr && hit(addr, `CTRL_ADDR);
	assign data_wr = wr && hit(addr, `DATA_ADDR);
	assign data_rd = rd && hit(addr, `DATA_ADDR);

	// Reserved bits two and three are neither stored nor acted on
	always_ff @(posedge clk) begin
		if (reset) begin
			slave_en_reg <= CFG_RESET_VALUE[`CFG_SLAVE_EN_BIT];
			master_req_reg <= CFG_RESET_VALUE[`CFG_MASTER_REQ_BIT];
			timer_run_reg <= CFG_RESET_VALUE[`CFG_TIMER_RUN_BIT];
			min_sel_reg <= CFG_RESET_VALUE[`CFG_SEL_HI_BIT:`CFG_SEL_LO_BIT];
		end else begin
			if (cfg_wr) begin
				slave_en_reg <= wdata[`CFG_SLAVE_EN_BIT];
				master_req_reg <= wdata[`CFG_MASTER_REQ_BIT];
				timer_run_reg <= wdata[`CFG_TIMER_RUN_BIT];
				min_sel_reg <= wdata[`CFG_SEL_HI_BIT:`CFG_SEL_LO_BIT];
			end
			if (timeout) begin
				slave_en_reg <= 1'b0;
			end
		end
	end

	// Time-out wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			overflow_reg <= 1'b0;
		end else if (timeout) begin
			overflow_reg <= 1'b1;
		end else if (cfg_wr && wdata[`CFG_TIMER_CLEAR_BIT]) begin
			overflow_reg <= 1'b0;
		end
	end

	assign master_active = (state_reg != m_idle);
	assign enabled = slave_en_reg || master_req_reg || master_active;

	////////////////////////////////////////////////////////////////////////////
	// Bus pins and conditions
	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(clk),
		.reset(reset),
		.async_in({sda_in, scl_in}),
		.sync_out(pins_s)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];

	always_ff @(posedge clk) begin
		if (reset) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d_reg;
	assign scl_fall = !scl_s && scl_d_reg;
	assign start_seen = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_seen = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	always_ff @(posedge clk) begin
		if (reset || !enabled || timeout) begin
			busy_reg <= 1'b0;
		end else if (start_seen) begin
			busy_reg <= 1'b1;
		end else if (stop_seen) begin
			busy_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Machine cycle and bus timer
	always_ff @(posedge clk) begin
		if (reset || !enabled) begin
			mc_count_reg <= 3'h0;
		end else if (mc_count_reg == `MACHINE_CLOCKS - 3'h1) begin
			mc_count_reg <= 3'h0;
		end else begin
			mc_count_reg <= mc_count_reg + 3'h1;
		end
	end

	assign mc_tick = enabled && (mc_count_reg == `MACHINE_CLOCKS - 3'h1);
	assign reload_value = 3'(`MIN_MET_COUNT - {1'b0, min_time_count(min_sel_reg)});
	assign timer_clear = !enabled || (cfg_wr && !wdata[`CFG_TIMER_RUN_BIT]);
	assign timer_reload = enabled && (scl_rise || scl_fall || start_seen || stop_seen);

	// Software slower than the time-out is treated as a hung bus
	bus_timer #(
		.WIDTH(`TIMER_WIDTH)
	) u_bus_timer (
		.clk(clk),
		.reset(reset),
		.tick(mc_tick),
		.clear(timer_clear),
		.reload(timer_reload),
		.reload_value(reload_value),
		.run_high(timer_run_reg),
		.frame(busy_reg),
		.min_met(min_met),
		.timeout(timeout)
	);

	////////////////////////////////////////////////////////////////////////////
	// Master sequencing
	assign stop_done = (state_reg == m_stop) && (state_next == m_idle);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			m_idle: begin
				if (master_req_reg && !busy_reg && min_met && scl_s && sda_s) begin
					state_next = m_start;
				end
			end
			m_start: begin
				if (!sda_s && !sda_d_reg && min_met) begin
					state_next = m_low;
				end
			end
			m_low: begin
				if (!scl_s && !scl_d_reg && min_met && !bit_data_ready_reg) begin
					state_next = m_high;
				end
			end
			m_high: begin
				if (scl_s && scl_d_reg && min_met) begin
					state_next = stop_pending_reg ? m_stop : m_low;
				end
			end
			m_stop: begin
				if (sda_s && sda_d_reg) begin
					state_next = m_idle;
				end
			end
			default: begin
				state_next = m_idle;
			end
		endcase
		if (timeout) begin
			state_next = m_idle;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= m_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || timeout || stop_done) begin
			stop_pending_reg <= 1'b0;
		end else if (ctrl_wr && wdata[`CTRL_SEND_STOP_BIT]) begin
			stop_pending_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data ready, attention and received bit
	assign bit_data_ready_set = enabled && (scl_rise || (state_reg == m_start && state_next == m_low));
	assign bit_data_ready_clr = data_wr || data_rd || (ctrl_wr && wdata[`CTRL_CLEAR_READY_BIT]);
	assign bit_data_ready_next = enabled && (bit_data_ready_set || (bit_data_ready_reg && !bit_data_ready_clr));

	always_ff @(posedge clk) begin
		if (reset) begin
			bit_data_ready_reg <= 1'b0;
			attention_reg <= 1'b0;
		end else begin
			bit_data_ready_reg <= bit_data_ready_next;
			attention_reg <= bit_data_ready_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_bit_reg <= 1'b0;
		end else if (scl_rise) begin
			rx_bit_reg <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit bit
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_bit_reg <= 1'b1;
		end else if (ctrl_wr && wdata[`CTRL_SEND_STOP_BIT]) begin
			tx_bit_reg <= 1'b0;
		end else if (data_wr) begin
			tx_bit_reg <= wdata[`DATA_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !enabled || timeout || stop_done) begin
			tx_active_reg <= 1'b0;
		end else if (data_wr || (ctrl_wr && wdata[`CTRL_SEND_STOP_BIT])) begin
			tx_active_reg <= 1'b1;
		end else if (data_rd || (ctrl_wr && wdata[`CTRL_CLEAR_XMIT_BIT])) begin
			tx_active_reg <= 1'b0;
		end
	end

	// An early write is held until SCL is low; only a release may pass while high
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_applied_reg <= 1'b0;
		end else if (!scl_s) begin
			tx_applied_reg <= tx_active_reg && !tx_bit_reg;
		end else if (!tx_active_reg) begin
			tx_applied_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			scl_out_reg <= 1'b0;
			sda_out_reg <= 1'b0;
		end else begin
			scl_oe_reg <= enabled && (state_next == m_low || (!scl_s && bit_data_ready_next));
			// Start holds SDA low until SCL is seen low, so the release cannot look like a stop
			sda_oe_reg <= enabled && (state_next == m_start || (state_reg == m_start && state_next == m_low)
				|| (state_reg == m_low && scl_s && sda_oe_reg) || (state_next != m_stop && tx_applied_reg));
			scl_out_reg <= 1'b0;
			sda_out_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset || !rd) begin
			rdata_reg <= 8'h00;
		end else begin
			case (addr)
				`CFG_ADDR: rdata_reg <= {slave_en_reg, master_req_reg, 1'b0, timer_run_reg, 2'h0, min_sel_reg};
				`CTRL_ADDR: rdata_reg <= {rx_bit_reg, attention_reg, bit_data_ready_reg, master_active,
					overflow_reg, busy_reg, stop_pending_reg, tx_active_reg};
				`DATA_ADDR: rdata_reg <= {rx_bit_reg, 7'h00};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign rdata = rdata_reg;
	assign scl_out = scl_out_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_out = sda_out_reg;
	assign sda_oe = sda_oe_reg;
	assign attention = attention_reg;

	////////////////////////////////////////////////////////////////////////////
	a_bus_disabled: assert property (!enabled |=> !scl_oe_reg && !sda_oe_reg)
		else $error("pins driven while disabled");
	a_slave_timeout: assert property (timeout |=> !slave_en_reg)
		else $error("slave enable kept after time-out");
	a_start_deferred: assert property (state_reg == m_idle && state_next == m_start |-> !busy_reg)
		else $error("start while bus busy");
	a_start_ready: assert property (state_reg == m_start && state_next == m_low |=> bit_data_ready_reg && attention_reg)
		else $error("no data ready after start");
	a_clear_reads: assert property (rd && hit(addr, `CFG_ADDR) |=> !rdata_reg[`CFG_TIMER_CLEAR_BIT])
		else $error("timer clear bit read as one");
	a_overflow_clear: assert property (cfg_wr && wdata[`CFG_TIMER_CLEAR_BIT] && !timeout |=> !overflow_reg)
		else $error("overflow not cleared");
	a_overflow_sticky: assert property (overflow_reg && !cfg_wr |=> overflow_reg)
		else $error("overflow dropped");
	a_overflow_set: assert property (timeout |=> overflow_reg)
		else $error("overflow not set");
	a_tx_on_low: assert property ($rose(tx_applied_reg) |-> !$past(scl_s))
		else $error("data drive began with SCL high");
	a_ready_rise: assert property (enabled && scl_rise |=> bit_data_ready_reg)
		else $error("data ready missed SCL rise");
	a_stretch_low: assert property (enabled && !scl_s && bit_data_ready_reg && !bit_data_ready_clr |=> scl_oe_reg)
		else $error("SCL not stretched");
	a_min_low: assert property (state_reg == m_low && state_next == m_high |-> min_met && !scl_d_reg)
		else $error("SCL low too short");
	a_min_high: assert property (state_reg == m_high && state_next != m_high && !timeout |-> min_met && scl_d_reg)
		else $error("SCL high too short");
	a_reload_select: assert property (min_sel_reg == 2'b10 |-> reload_value == 3'h1)
		else $error("reload for select 10 wrong");
	a_reload_fast: assert property (min_sel_reg == 2'b11 |-> reload_value == 3'h4)
		else $error("reload for select 11 wrong");
	a_run_clear: assert property (cfg_wr && !wdata[`CFG_TIMER_RUN_BIT] |=> !timer_run_reg ##1 !timeout)
		else $error("timer still running after stop");
endmodule // i2c_config_and_bus_timer
`default_nettype wire

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for the bus pins.
// Assumes pulled-up lines, so reset shows them high.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pins and their synchronised copies
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1_reg <= '1;
			stage2_reg <= '1;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;
endmodule // pin_sync
`default_nettype wire

// ==== tb/i2c_bus_partner.sv ====
// Far-side bus model: another master making start, stop and clock phases.
// Assumes the bench resolves the open-drain wires with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_partner (
	// Resolved wires
	input wire logic scl,
	input wire logic sda,
	// Pull-down enables
	output logic scl_low,
	output logic sda_low
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Start leaves both lines held low, so the bus counts as busy
	task automatic start_cond();
		#5;
		sda_low = 1'b1;
		#160;
		scl_low = 1'b1;
		#155;
	endtask
	// Waits for the wire itself, so a stretching device is honoured
	task automatic stop_cond();
		#5;
		sda_low = 1'b1;
		#80;
		scl_low = 1'b0;
		wait (scl === 1'b1);
		#165;
		sda_low = 1'b0;
		#155;
	endtask
	// Half of a 160 ns link period
	// Wire changes land off the bench clock edges
	task automatic scl_set(input logic low);
		#5;
		scl_low = low;
		#75;
	endtask
endmodule // i2c_bus_partner
`default_nettype wire

// ==== tb/i2c_config_and_bus_timer_bench.sv ====
// Self-checking bench for the configuration register and bus timer.
// Assumes the bus partner model and pull-ups on both wires.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_cfg_map.svh"
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module i2c_config_and_bus_timer_bench;
	import i2c_cfg_pkg::*;
	logic clk, reset, wr, rd;
	logic [7:0] addr, wdata, rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, attention;
	logic scl_w, sda_w, scl_low, sda_low;
	int num_errors = 0;
	int checks_done = 0;
	int tmo_cycles [4] = '{1021, 1022, 1023, 1020};
	// Open drain: any party pulling low wins
	assign scl_w = !(scl_oe | scl_low);
	assign sda_w = !(sda_oe | sda_low);
	i2c_config_and_bus_timer u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .attention(attention));
	i2c_bus_partner u_peer (.scl(scl_w), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, output reg_byte_t d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Bounded wait; n is one less than the cycles taken
	task automatic wait_for(input int sel, input logic v, output int n);
		logic s;
		for (n = 0; n < 3000; n++) begin
			@(posedge clk);
			#1;
			s = (sel == 0) ? sda_oe : (sel == 1) ? scl_oe : attention;
			if (s === v) break;
		end
		if (n == 3000) begin
			num_errors++;
			$display("[FAIL] wait for signal %0d expected %h seen timeout", sel, v);
		end
	endtask
	task automatic conclude();
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// About 60k cycles, half again the length of a clean run
	initial begin
		#1200000;
		num_errors++;
		conclude();
	end
	initial begin
		reg_byte_t d;
		int n;
		logic [1:0] sel;
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		reg_read(`CFG_ADDR, d);
		`CHECK("cfg reset", 8'h00, d)
		reg_write(`CFG_ADDR, 8'hb3);
		reg_read(`CFG_ADDR, d);
		`CHECK("cfg readback", 8'h93, d)
		@(posedge clk);
		#1;
		`CHECK("rdata after one cycle", 8'h00, rdata)
		reg_read(8'h00, d);
		`CHECK("unmapped read", 8'h00, d)
		// Slave: data ready on rise, early bit held off SDA, stretching
		reg_write(`CFG_ADDR, 8'h80);
		u_peer.scl_set(1'b1);
		u_peer.scl_set(1'b0);
		wait_for(2, 1'b1, n);
		`CHECK("ready on rise", 1'b1, attention)
		reg_read(`DATA_ADDR, d);
		`CHECK("received bit", 8'h80, d)
		reg_write(`DATA_ADDR, 8'h00);
		repeat (20) begin
			@(posedge clk);
			#1;
			`CHECK("sda held while high", 1'b0, sda_oe)
		end
		u_peer.scl_set(1'b1);
		repeat (8) @(posedge clk);
		#1;
		`CHECK("sda once low", 1'b1, sda_oe)
		`CHECK("sda_out level", 1'b0, sda_out)
		u_peer.scl_set(1'b0);
		u_peer.scl_set(1'b1);
		u_peer.scl_set(1'b1);
		u_peer.scl_set(1'b0);
		repeat (6) @(posedge clk);
		#1;
		`CHECK("stretch", 1'b0, scl_w)
		`CHECK("scl_out level", 1'b0, scl_out)
		reg_write(`CTRL_ADDR, 8'h22);
		wait_for(1, 1'b0, n);
		`CHECK("stretch released", 1'b1, scl_w)
		// Disabled: no flag, no drive
		reg_write(`CFG_ADDR, 8'h00);
		reg_write(`CTRL_ADDR, 8'h20);
		repeat (2) begin
			u_peer.scl_set(1'b1);
			u_peer.scl_set(1'b0);
		end
		repeat (4) @(posedge clk);
		#1;
		`CHECK("disabled ready", 1'b0, attention)
		`CHECK("disabled scl", 1'b0, scl_oe)
		// Time-out per select code, checked just before and just after
		for (int i = 0; i < 4; i++) begin
			sel = 2'(i);
			reg_write(`CFG_ADDR, {6'h24, sel});
			u_peer.start_cond();
			repeat (6 * tmo_cycles[sel] - 40) @(posedge clk);
			reg_read(`CFG_ADDR, d);
			`CHECK("no early timeout", {6'h24, sel}, d)
			repeat (60) @(posedge clk);
			reg_read(`CFG_ADDR, d);
			`CHECK("timeout clears slave", {6'h04, sel}, d)
			reg_read(`CTRL_ADDR, d);
			`CHECK("overflow set", 1'b1, d[3])
			reg_write(`CFG_ADDR, {6'h0c, sel});
			reg_read(`CTRL_ADDR, d);
			`CHECK("overflow cleared", 1'b0, d[3])
			u_peer.stop_cond();
		end
		// Run bit zero clears the count and blocks the hang check
		reg_write(`CFG_ADDR, 8'h90);
		u_peer.start_cond();
		repeat (4000) @(posedge clk);
		reg_write(`CFG_ADDR, 8'h80);
		reg_write(`CFG_ADDR, 8'h90);
		repeat (4000) @(posedge clk);
		reg_read(`CFG_ADDR, d);
		`CHECK("run zero clears", 8'h90, d)
		reg_write(`CFG_ADDR, 8'h80);
		repeat (6200) @(posedge clk);
		reg_read(`CFG_ADDR, d);
		`CHECK("no hang check", 8'h80, d)
		u_peer.stop_cond();
		reg_write(`CTRL_ADDR, 8'h20);
		// Master request while busy waits for stop
		u_peer.start_cond();
		reg_write(`CFG_ADDR, 8'h41);
		repeat (200) @(posedge clk);
		#1;
		`CHECK("deferred start", 1'b0, sda_oe)
		u_peer.stop_cond();
		reg_write(`CTRL_ADDR, 8'h20);
		wait_for(0, 1'b1, n);
		`CHECK("start sent", 1'b1, sda_oe)
		wait_for(1, 1'b1, n);
		`CHECK("start hold time", 1'b1, (n >= 30))
		`CHECK("start ready", 1'b1, attention)
		reg_write(`DATA_ADDR, 8'h80);
		wait_for(1, 1'b0, n);
		wait_for(1, 1'b1, n);
		`CHECK("scl min high", 1'b1, (n >= 30))
		// Stop as master
		reg_write(`CFG_ADDR, 8'h01);
		reg_write(`CTRL_ADDR, 8'h21);
		wait_for(1, 1'b0, n);
		wait_for(0, 1'b0, n);
		`CHECK("stop setup time", 1'b1, (n >= 30))
		`CHECK("stop with scl high", 1'b1, scl_w)
		conclude();
	end
endmodule // i2c_config_and_bus_timer_bench
`default_nettype wire
